/* File: include/vsds_pkg.sv */
// Purpose: shared constants and carriers for the vertex stage dispatch block
// Assumes: 32-bit AHB-Lite register access, single word transfers only
// Notes:   state words are mirrored as plain registers at word offsets
package vsds_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] VSDS_OFF_WORD1   = 8'h04;
    localparam logic [7:0] VSDS_OFF_WORD2   = 8'h08;
    localparam logic [7:0] VSDS_OFF_WORD3   = 8'h0c;
    localparam logic [7:0] VSDS_OFF_WORD4   = 8'h10;
    localparam logic [7:0] VSDS_OFF_WORD6   = 8'h18;
    localparam logic [7:0] VSDS_OFF_CTRL    = 8'h20;
    localparam logic [7:0] VSDS_OFF_STATUS  = 8'h24;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int VSDS_W1_SINGLE_FLOW  = 31;
    localparam int VSDS_W1_PRIORITY     = 17;
    localparam int VSDS_W1_FLOAT_MODE   = 16;
    localparam int VSDS_W1_EXC_OPCODE   = 13;
    localparam int VSDS_W1_EXC_MASK     = 11;
    localparam int VSDS_W1_EXC_SOFT     = 7;
    localparam int VSDS_W2_BASE_LSB     = 10;
    localparam int VSDS_W2_SIZE_LSB     = 0;
    localparam int VSDS_W3_CLEN_LSB     = 25;
    localparam int VSDS_W3_COFF_LSB     = 18;
    localparam int VSDS_W3_VLEN_LSB     = 11;
    localparam int VSDS_W3_VOFF_LSB     = 4;
    localparam int VSDS_W3_START_LSB    = 0;
    localparam int VSDS_W4_MAXTHR_LSB   = 25;
    localparam int VSDS_W4_ALLOC_LSB    = 19;
    localparam int VSDS_W4_ENTRIES_LSB  = 11;
    localparam int VSDS_W6_ENABLE       = 0;
    // thread control register layout
    localparam int VSDS_TC_EXC_OPCODE   = 12;
    localparam int VSDS_TC_EXC_MASK     = 11;
    localparam int VSDS_TC_EXC_SOFT     = 13;

    // ------------------------------------------------------------
    // reset values and limits
    // ------------------------------------------------------------
    localparam logic [31:0] VSDS_RST_WORD   = 32'h0000_0000;
    localparam logic [3:0]  VSDS_SIZE_MAX   = 4'hb;
    localparam int          VSDS_SCR_SHIFT  = 10;
    localparam logic [1:0]  VSDS_HTRANS_NSQ = 2'h2;

    // decoded state latched at each load
    typedef struct packed {
        logic        single_flow;
        logic        high_priority;
        logic        alt_float;
        logic [15:0] thread_control;
        logic [21:0] scratch_base;
        logic [3:0]  scratch_size;
        logic [5:0]  const_len;
        logic [5:0]  const_off;
        logic [5:0]  vert_len;
        logic [5:0]  vert_off;
        logic [3:0]  start_reg;
        logic [4:0]  max_threads_m1;
        logic [4:0]  alloc_units_m1;
        logic [6:0]  entry_count;
        logic        shade_enable;
    } vsds_state_t;

    // one dispatched thread
    typedef struct packed {
        logic        two_vertex;
        logic        high_priority;
        logic        alt_float;
        logic [15:0] thread_control;
        logic [31:0] scratch_offset;
        logic [3:0]  scratch_size;
        logic [5:0]  const_len;
        logic [5:0]  const_off;
        logic [5:0]  vert_len;
        logic [5:0]  vert_off;
        logic [3:0]  start_reg;
        logic [4:0]  slot;
    } vsds_thread_t;

endpackage

/* File: src/vsds_slot_pool.sv */
// Purpose: tracks busy thread slots and hands out the lowest free one
// Assumes: a slot is never retired while it is free
// Notes:   limit caps the number of slots that may be busy at once
`timescale 1ns/10ps
module vsds_slot_pool #(
    parameter int SLOTS = 32
) (
    // clock and reset
    input  wire logic                     clock,
    input  wire logic                     reset,
    // allocation
    input  wire logic [$clog2(SLOTS)-1:0] limit_m1,
    input  wire logic                     take,
    output logic                          avail,
    output logic [$clog2(SLOTS)-1:0]      free_slot,
    // retirement
    input  wire logic                     retire,
    input  wire logic [$clog2(SLOTS)-1:0] retire_slot,
    output logic [$clog2(SLOTS):0]        active
);
    typedef struct packed {
        logic [SLOTS-1:0]         busy;
        logic [$clog2(SLOTS):0]   count;
    } vsds_pool_t;

    vsds_pool_t s_q;
    vsds_pool_t s_d;
    logic       found;

    always_comb begin
        s_d       = s_q;
        found     = 1'b0;
        free_slot = '0;
        for (int i = 0; i < SLOTS; i++) begin
            if (!found && !s_q.busy[i]) begin
                found     = 1'b1;
                free_slot = i[$clog2(SLOTS)-1:0];
            end
        end
        // limit_m1 is the cap minus one, so a take is allowed while count is at most limit_m1
        avail = found && (s_q.count <= {1'b0, limit_m1});
        if (take && avail) begin
            s_d.busy[free_slot] = 1'b1;
        end
        if (retire) begin
            s_d.busy[retire_slot] = 1'b0;
        end
        s_d.count = s_q.count + (($clog2(SLOTS)+1)'(take && avail)) - (($clog2(SLOTS)+1)'(retire));
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign active = s_q.count;
endmodule

/* File: src/vsds_dispatch.sv */
// Purpose: decodes vertex stage state and dispatches shading threads
// Assumes: AHB-Lite single word transfers, zero wait state answers
// Notes:   vertices arrive as a valid/ready stream of handles
//
// The implementer's own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/10ps

module vsds_dispatch
    import vsds_pkg::*;
#(
    parameter int SLOTS = 32
) (
    // clock and reset
    input  wire logic                    clock,
    input  wire logic                    reset,
    // ahb-lite slave
    input  wire logic                    hsel,
    input  wire logic [31:0]             haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic [31:0]             hwdata,
    input  wire logic                    hready,
    output logic                         hreadyout,
    output logic                         hresp,
    output logic [31:0]                  hrdata,
    // incoming vertices from the fetch unit
    input  wire logic                    vtx_valid,
    input  wire logic [15:0]             vtx_handle,
    input  wire logic                    vtx_flush,
    output logic                         vtx_ready,
    // vertices passed down the pipeline unshaded
    output logic                         pass_valid,
    output logic [15:0]                  pass_handle,
    // threads to the execution units
    output logic                         thr_valid,
    output vsds_pkg::vsds_thread_t       thr_info,
    output logic [15:0]                  thr_handle0,
    output logic [15:0]                  thr_handle1,
    input  wire logic                    thr_ready,
    input  wire logic                    thr_done,
    input  wire logic [4:0]              thr_done_slot,
    // return buffer allocation seen by the buffer manager
    output logic [6:0]                   entry_count,
    output logic [4:0]                   entry_units_m1
);
    import vsds_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        VSDS_IDLE = 3'b001,
        VSDS_HOLD = 3'b010,
        VSDS_SEND = 3'b100
    } vsds_phase_t;

    typedef struct packed {
        logic [31:0]   word1;
        logic [31:0]   word2;
        logic [31:0]   word3;
        logic [31:0]   word4;
        logic [31:0]   word6;
        vsds_state_t   cur;
        logic          ap_valid;
        logic          ap_write;
        logic [7:0]    ap_addr;
        logic [31:0]   rdata;
        vsds_phase_t   phase;
        logic [15:0]   held;
        logic          pv;
        logic [15:0]   ph;
        logic          tv;
        vsds_thread_t  ti;
        logic [15:0]   th0;
        logic [15:0]   th1;
        logic [31:0]   dispatched;
    } vsds_regs_t;

    vsds_regs_t  r_q;
    vsds_regs_t  r_d;
    logic        slot_avail;
    logic [4:0]  slot_free;
    logic [5:0]  slot_active;
    logic        take;
    vsds_state_t dec;

    // ------------------------------------------------------------
    // slot tracking
    // ------------------------------------------------------------
    vsds_slot_pool #(
        .SLOTS (SLOTS)
    ) u_pool (
        .clock       (clock),
        .reset       (reset),
        .limit_m1    (r_q.cur.max_threads_m1),
        .take        (take),
        .avail       (slot_avail),
        .free_slot   (slot_free),
        .retire      (thr_done),
        .retire_slot (thr_done_slot),
        .active      (slot_active)
    );

    // ------------------------------------------------------------
    // decode of the programmed words
    // ------------------------------------------------------------
    function automatic vsds_state_t decode(input logic [31:0] w1, input logic [31:0] w2,
                                           input logic [31:0] w3, input logic [31:0] w4,
                                           input logic [31:0] w6);
        vsds_state_t s;
        s                = '0;
        s.single_flow    = w1[VSDS_W1_SINGLE_FLOW];
        s.high_priority  = w1[VSDS_W1_PRIORITY];
        s.alt_float      = w1[VSDS_W1_FLOAT_MODE];
        s.thread_control[VSDS_TC_EXC_OPCODE] = w1[VSDS_W1_EXC_OPCODE];
        s.thread_control[VSDS_TC_EXC_MASK]   = w1[VSDS_W1_EXC_MASK];
        s.thread_control[VSDS_TC_EXC_SOFT]   = w1[VSDS_W1_EXC_SOFT];
        s.scratch_base   = w2[31:VSDS_W2_BASE_LSB];
        s.scratch_size   = w2[VSDS_W2_SIZE_LSB +: 4];
        s.const_len      = w3[VSDS_W3_CLEN_LSB +: 6];
        s.const_off      = w3[VSDS_W3_COFF_LSB +: 6];
        s.vert_len       = w3[VSDS_W3_VLEN_LSB +: 6];
        s.vert_off       = w3[VSDS_W3_VOFF_LSB +: 6];
        s.start_reg      = w3[VSDS_W3_START_LSB +: 4];
        s.max_threads_m1 = w4[VSDS_W4_MAXTHR_LSB +: 5];
        s.alloc_units_m1 = w4[VSDS_W4_ALLOC_LSB +: 5];
        s.entry_count    = w4[VSDS_W4_ENTRIES_LSB +: 7];
        s.shade_enable   = w6[VSDS_W6_ENABLE];
        return s;
    endfunction

    assign dec = decode(r_q.word1, r_q.word2, r_q.word3, r_q.word4, r_q.word6);

    // ------------------------------------------------------------
    // thread build
    // ------------------------------------------------------------
    function automatic vsds_thread_t build(input vsds_state_t s, input logic pair, input logic [4:0] slot);
        vsds_thread_t t;
        logic [31:0]  kb;
        t                = '0;
        t.two_vertex     = pair;
        t.high_priority  = s.high_priority;
        t.alt_float      = s.alt_float;
        t.thread_control = s.thread_control;
        // each slot owns 2^size kilobytes past the base
        kb               = 32'(s.scratch_base) + (32'(slot) << s.scratch_size);
        t.scratch_offset = kb << VSDS_SCR_SHIFT;
        t.scratch_size   = s.scratch_size;
        t.const_len      = s.const_len;
        t.const_off      = s.const_off;
        t.vert_len       = s.vert_len;
        t.vert_off       = s.vert_off;
        t.start_reg      = s.start_reg;
        t.slot           = slot;
        return t;
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic ap_take;
    logic send_free;

    always_comb begin
        r_d       = r_q;
        ap_take   = hsel && hready && (htrans == VSDS_HTRANS_NSQ);
        send_free = !r_q.tv || thr_ready;
        take      = 1'b0;
        vtx_ready = 1'b0;

        // register bus: address phase captured, data phase acted on
        r_d.ap_valid = ap_take;
        r_d.ap_write = hwrite;
        r_d.ap_addr  = haddr[7:0];
        if (r_q.ap_valid && r_q.ap_write) begin
            case (r_q.ap_addr)
                VSDS_OFF_WORD1: r_d.word1 = hwdata;
                VSDS_OFF_WORD2: r_d.word2 = hwdata;
                VSDS_OFF_WORD3: r_d.word3 = hwdata;
                VSDS_OFF_WORD4: r_d.word4 = hwdata;
                VSDS_OFF_WORD6: r_d.word6 = hwdata;
                // writing the control word loads the structure
                VSDS_OFF_CTRL: r_d.cur   = dec;
                default: r_d.word1 = r_d.word1;
            endcase
        end
        if (ap_take && !hwrite) begin
            case (haddr[7:0])
                VSDS_OFF_WORD1:  r_d.rdata = r_q.word1;
                VSDS_OFF_WORD2:  r_d.rdata = r_q.word2;
                VSDS_OFF_WORD3:  r_d.rdata = r_q.word3;
                VSDS_OFF_WORD4:  r_d.rdata = r_q.word4;
                VSDS_OFF_WORD6:  r_d.rdata = r_q.word6;
                VSDS_OFF_STATUS: r_d.rdata = {r_q.dispatched[23:0], 1'b0, r_q.phase == VSDS_HOLD,
                                              slot_active};
                default:         r_d.rdata = 32'h0000_0000;
            endcase
        end

        // pass output of last cycle is dropped, a thread output only once thr_ready takes it
        r_d.pv = 1'b0;
        if (r_q.tv && thr_ready) begin
            r_d.tv = 1'b0;
        end

        if (!r_q.cur.shade_enable) begin
            // dispatch fields disregarded, vertices flow through
            vtx_ready = 1'b1;
            if (vtx_valid) begin
                r_d.pv = 1'b1;
                r_d.ph = vtx_handle;
            end
            r_d.phase = VSDS_IDLE;
        end else begin
            case (r_q.phase)
                VSDS_IDLE: begin
                    vtx_ready = send_free && slot_avail;
                    if (vtx_valid && vtx_ready) begin
                        if (r_q.cur.single_flow || vtx_flush) begin
                            // lone vertex thread
                            take     = 1'b1;
                            r_d.tv   = 1'b1;
                            r_d.ti   = build(r_q.cur, 1'b0, slot_free);
                            r_d.th0  = vtx_handle;
                            r_d.th1  = 16'h0000;
                        end else begin
                            r_d.held  = vtx_handle;
                            r_d.phase = VSDS_HOLD;
                        end
                    end
                end
                VSDS_HOLD: begin
                    vtx_ready = send_free && slot_avail;
                    if (vtx_valid && vtx_ready) begin
                        take      = 1'b1;
                        r_d.tv    = 1'b1;
                        r_d.ti    = build(r_q.cur, 1'b1, slot_free);
                        r_d.th0   = r_q.held;
                        r_d.th1   = vtx_handle;
                        r_d.phase = VSDS_IDLE;
                    end else if (vtx_flush && send_free && slot_avail) begin
                        // no partner is coming, send the held vertex alone
                        take      = 1'b1;
                        r_d.tv    = 1'b1;
                        r_d.ti    = build(r_q.cur, 1'b0, slot_free);
                        r_d.th0   = r_q.held;
                        r_d.th1   = 16'h0000;
                        r_d.phase = VSDS_IDLE;
                    end
                end
                default: r_d.phase = VSDS_IDLE;
            endcase
        end
        if (take) begin
            r_d.dispatched = r_q.dispatched + 32'h0000_0001;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            r_q       <= '0;
            r_q.phase <= VSDS_IDLE;
        end else begin
            r_q <= r_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign hreadyout      = 1'b1;
    assign hresp          = 1'b0;
    assign hrdata         = r_q.rdata;
    assign pass_valid     = r_q.pv;
    assign pass_handle    = r_q.ph;
    assign thr_valid      = r_q.tv;
    assign thr_info       = r_q.ti;
    assign thr_handle0    = r_q.th0;
    assign thr_handle1    = r_q.th1;
    // allocation follows the written words at once, enabled or not
    assign entry_count    = r_q.word4[VSDS_W4_ENTRIES_LSB +: 7];
    assign entry_units_m1 = r_q.word4[VSDS_W4_ALLOC_LSB +: 5];
endmodule

/* File: verif/vsds_dispatch_properties.sv */
// Purpose: port-level checks for the vertex stage dispatch block
// Assumes: state words are snooped from single-word bus writes
// Notes:   snooped copies latch on the ctrl write, as the design does
`timescale 1ns/10ps
module vsds_dispatch_checker
    import vsds_pkg::*;
(
    // clock and reset
    input wire logic                   clock,
    input wire logic                   reset,
    // bus
    input wire logic                   hsel,
    input wire logic [31:0]            haddr,
    input wire logic [1:0]             htrans,
    input wire logic                   hwrite,
    input wire logic [31:0]            hwdata,
    input wire logic                   hready,
    input wire logic                   hreadyout,
    input wire logic                   hresp,
    // streams
    input wire logic                   vtx_valid,
    input wire logic                   vtx_ready,
    input wire logic [15:0]            vtx_handle,
    input wire logic                   pass_valid,
    input wire logic [15:0]            pass_handle,
    input wire logic                   thr_valid,
    input wire vsds_pkg::vsds_thread_t thr_info,
    input wire logic                   thr_ready,
    input wire logic                   thr_done,
    input wire logic [6:0]             entry_count,
    input wire logic [4:0]             entry_units_m1
);
    // ----------
    // snooped state
    // ----------
    logic [7:0]  wa_q;
    logic        wp_q;
    logic [31:0] w1_q, w2_q, w4_q, l1_q, l2_q;
    logic [4:0]  lim_q;
    logic        w6_q, en_q;
    logic [6:0]  act_q;
    wire         wr = wp_q && hready;
    always_ff @(posedge clock) begin
        if (hready) begin
            wp_q <= hsel && hwrite && htrans == VSDS_HTRANS_NSQ;
            wa_q <= haddr[7:0];
        end
        if (wr && wa_q == VSDS_OFF_WORD1) w1_q <= hwdata;
        if (wr && wa_q == VSDS_OFF_WORD2) w2_q <= hwdata;
        if (wr && wa_q == VSDS_OFF_WORD4) w4_q <= hwdata;
        if (wr && wa_q == VSDS_OFF_WORD6) w6_q <= hwdata[0];
        if (wr && wa_q == VSDS_OFF_CTRL) begin
            l1_q  <= w1_q;
            l2_q  <= w2_q;
            lim_q <= w4_q[29:25];
            en_q  <= w6_q;
        end
        // counts dispatched minus retired, so a late slot release is tolerated
        act_q <= act_q + 7'(thr_valid && thr_ready) - 7'(thr_done);
        if (reset) begin
            wp_q  <= 1'b0;
            lim_q <= 5'h0;
            en_q  <= 1'b0;
            act_q <= 7'h0;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    sequence s_take; vtx_valid && vtx_ready; endsequence
    sequence s_stall; thr_valid && !thr_ready; endsequence
    sequence s_wr4; wr && wa_q == VSDS_OFF_WORD4; endsequence
    bus_okay_a: assert property (hreadyout && !hresp) else $error("bus answer not ready okay");
    thr_hold_a: assert property (s_stall |=> thr_valid && $stable(thr_info))
        else $error("pending thread dropped or changed");
    one_vertex_a: assert property (thr_valid && l1_q[31] |-> !thr_info.two_vertex)
        else $error("two-vertex thread in single flow");
    prio_mode_a: assert property (thr_valid |-> thr_info.high_priority == l1_q[17]
        && thr_info.alt_float == l1_q[16]) else $error("priority or float mode wrong");
    exc_bits_a: assert property (thr_valid |-> thr_info.thread_control
        == {2'h0, l1_q[7], l1_q[13], l1_q[11], 11'h0}) else $error("thread control wrong");
    scr_align_a: assert property (thr_valid |-> thr_info.scratch_offset[9:0] == 10'h0
        && thr_info.scratch_size == l2_q[3:0] && thr_info.scratch_offset[31:10] >= l2_q[31:10])
        else $error("scratch offset or size wrong");
    thr_limit_a: assert property (act_q <= {2'h0, lim_q} + 7'h1) else $error("too many threads");
    entry_live_a: assert property (s_wr4 |=> entry_count == $past(hwdata[17:11])
        && entry_units_m1 == $past(hwdata[23:19])) else $error("entry fields not updated");
    pass_thru_a: assert property (s_take ##0 !en_q |=> pass_valid
        && pass_handle == $past(vtx_handle)) else $error("vertex not passed through");
    no_thread_a: assert property (!en_q |-> !thr_valid) else $error("thread while disabled");
endmodule
bind vsds_dispatch vsds_dispatch_checker chk (
    .clock, .reset, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp,
    .vtx_valid, .vtx_ready, .vtx_handle, .pass_valid, .pass_handle, .thr_valid, .thr_info,
    .thr_ready, .thr_done, .entry_count, .entry_units_m1
);

/* File: verif/vsds_eu_model.sv */
// Purpose: execution unit model that accepts threads and retires them later
// Assumes: retirement in acceptance order after a fixed delay
// Notes:   slow mode accepts on every third cycle only
`timescale 1ns/10ps
module vsds_eu_model
    import vsds_pkg::*;
#(
    parameter int DELAY = 60
) (
    // clock and reset
    input  wire logic                   clock,
    input  wire logic                   reset,
    // thread side
    input  wire logic                   slow,
    input  wire logic                   thr_valid,
    input  wire vsds_pkg::vsds_thread_t thr_info,
    output logic                        thr_ready = 1'b0,
    output logic                        thr_done = 1'b0,
    output logic [4:0]                  thr_done_slot = 5'h0
);
    logic [4:0] slot_q[$];
    int         due_q[$];
    int         cyc = 0;
    always @(posedge clock) begin
        cyc <= cyc + 1;
        thr_ready <= !reset && (!slow || cyc % 3 == 0);
        if (reset) begin
            slot_q.delete();
            due_q.delete();
        end else begin
            if (thr_valid && thr_ready) begin
                slot_q.push_back(thr_info.slot);
                due_q.push_back(cyc + DELAY);
            end
            if (due_q.size() > 0 && due_q[0] <= cyc) begin
                thr_done <= 1'b1;
                thr_done_slot <= slot_q.pop_front();
                void'(due_q.pop_front());
            end else begin
                thr_done <= 1'b0;
                // no stale slot when idle, so a design sampling it unqualified is caught
                thr_done_slot <= 5'(cyc) ^ 5'h15;
            end
        end
    end
endmodule

/* File: verif/vsds_dispatch_tb_top.sv */
// Purpose: self-checking bench for the vertex stage dispatch block
// Assumes: one bus master, execution units from vsds_eu_model
// Notes:   each batch starts idle, so slot numbers are predictable
`timescale 1ns/10ps
module vsds_dispatch_tb_top;
    import vsds_pkg::*;
    typedef struct packed {
        vsds_thread_t info;
        logic [15:0]  h0;
        logic [15:0]  h1;
    } vsds_exp_t;
    logic         clock = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0, slow = 1'b0;
    logic [31:0]  haddr = 32'h0, hwdata = 32'h0, hrdata, w1, w2, w3, w4;
    logic [1:0]   htrans = 2'h0;
    logic [2:0]   hsize = 3'h0;
    logic         hreadyout, hresp, vtx_ready, pass_valid, thr_valid, thr_ready, thr_done;
    logic         vtx_valid = 1'b0, vtx_flush = 1'b0;
    logic [15:0]  vtx_handle = 16'h0, pass_handle, thr_handle0, thr_handle1;
    logic [4:0]   thr_done_slot, entry_units_m1;
    logic [6:0]   entry_count;
    vsds_thread_t thr_info;
    vsds_exp_t    ex, tq[$];
    logic [15:0]  pq[$];
    logic [31:0]  seed = 32'h5b2528ee;
    int           errors = 0, compares = 0;
    int           ent[5] = '{8, 12, 16, 32, 64};
    vsds_dispatch #(.SLOTS(32)) dut (.clock, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .vtx_valid, .vtx_handle, .vtx_flush, .vtx_ready,
        .pass_valid, .pass_handle, .thr_valid, .thr_info, .thr_handle0, .thr_handle1, .thr_ready,
        .thr_done, .thr_done_slot, .entry_count, .entry_units_m1);
    vsds_eu_model eu (.clock, .reset, .slow, .thr_valid, .thr_info, .thr_ready, .thr_done, .thr_done_slot);
    initial forever #50 clock = ~clock;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic vsds_exp_t mk(logic two, logic [4:0] s, logic [15:0] a, logic [15:0] b);
        mk.info = '{two, w1[17], w1[16], {2'h0, w1[7], w1[13], w1[11], 11'h0},
            (32'(w2[31:10]) + (32'(s) << w2[3:0])) << 10, w2[3:0], w3[30:25], w3[23:18],
            w3[16:11], w3[9:4], w3[3:0], s};
        mk.h0 = a;
        mk.h1 = b;
    endfunction
    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmpthr(input vsds_exp_t got, input vsds_exp_t exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= VSDS_HTRANS_NSQ;
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge clock); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic vtx(input logic [15:0] h, input logic f);
        vtx_valid <= 1'b1;
        vtx_handle <= h;
        vtx_flush <= f;
        do @(posedge clock); while (vtx_ready !== 1'b1);
    endtask
    task automatic end_of_test();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clock) begin
        if (!reset && pass_valid) cmp32(32'(pass_handle), pq.size() > 0 ? 32'(pq.pop_front()) : '1);
        if (!reset && thr_valid && thr_ready) begin
            ex = tq.size() > 0 ? tq.pop_front() : '1;
            cmpthr({thr_info, thr_handle0, ex.info.two_vertex ? thr_handle1 : ex.h1}, ex);
        end
    end
    initial begin
        repeat (30000) @(posedge clock);
        errors++;
        end_of_test();
    end
    initial begin
        logic [31:0] q;
        logic [15:0] h[3];
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        bus(1'b1, 8'h40, 32'h1234_5678, q);
        bus(1'b0, 8'h40, 32'h0, q);
        cmp32(q, 32'h0);
        bus(1'b0, VSDS_OFF_WORD1, 32'h0, q);
        cmp32(q, VSDS_RST_WORD);
        for (int k = 0; k < 7; k++) begin
            do bus(1'b0, VSDS_OFF_STATUS, 32'h0, q); while (q[5:0] !== 6'h0);
            w1 = (rnd() & 32'h0003_2880) | {k[0], 31'h0};
            w2 = (rnd() & 32'h00ff_fc00) | 32'(rnd() % 12);
            w3 = (rnd() & 32'h7efd_fbff) | 32'h800;
            w4 = (rnd() & 32'h00f8_0000) | (32'(ent[rnd() % 5]) << 11);
            if (k != 5) w4 = w4 | 32'h0600_0000 | (rnd() & 32'h3e00_0000);
            bus(1'b1, VSDS_OFF_WORD1, w1, q);
            bus(1'b1, VSDS_OFF_WORD2, w2, q);
            bus(1'b1, VSDS_OFF_WORD3, w3, q);
            bus(1'b1, VSDS_OFF_WORD4, w4, q);
            bus(1'b1, VSDS_OFF_WORD6, 32'(k != 0), q);
            bus(1'b1, VSDS_OFF_CTRL, 32'h1, q);
            // a word write without ctrl must not touch the running state
            bus(1'b1, VSDS_OFF_WORD1, ~w1, q);
            bus(1'b0, VSDS_OFF_WORD3, 32'h0, q);
            cmp32(q, w3);
            cmp32({20'h0, entry_units_m1, entry_count}, {20'h0, w4[23:19], w4[17:11]});
            for (int i = 0; i < 3; i++) h[i] = 16'(rnd());
            if (k == 0) begin
                for (int i = 0; i < 3; i++) pq.push_back(h[i]);
            end else if (k[0]) begin
                for (int i = 0; i < 3; i++) tq.push_back(mk(1'b0, k == 5 ? 5'h0 : 5'(i), h[i], 16'h0));
            end else begin
                tq.push_back(mk(1'b1, 5'h0, h[0], h[1]));
                tq.push_back(mk(1'b0, 5'h1, h[2], 16'h0));
            end
            slow <= k[1];
            for (int i = 0; i < 3; i++) vtx(h[i], i == 2 && k != 4);
            vtx_valid <= 1'b0;
            vtx_flush <= k == 4;
        end
        do bus(1'b0, VSDS_OFF_STATUS, 32'h0, q); while (q[5:0] !== 6'h0);
        cmp32(32'(tq.size() + pq.size()), 32'h0);
        end_of_test();
    end
endmodule
